// file: verilog/lpmc_pkg.sv
// constants and types shared by the low-power mode controller
// assumes a 25 MHz pclk and an 8-bit APB address window
package lpmc_pkg;
	// ==========================================
	// register map
	localparam logic [7:0] LPMC_ADDR_SYS_CTRL_1 = 8'h00;
	localparam logic [7:0] LPMC_ADDR_SYS_CTRL_2 = 8'h04;
	localparam logic [7:0] LPMC_ADDR_INT_CTRL   = 8'h08;
	localparam logic [7:0] LPMC_ADDR_INT_LATCH  = 8'h0C;
	localparam logic [7:0] LPMC_ADDR_STATUS     = 8'h10;
	// ==========================================
	// field positions
	localparam int LPMC_STOP_BIT   = 7;
	localparam int LPMC_REL_MODE_BIT  = 6;
	localparam int LPMC_EXIT_MODE_BIT = 5;
	localparam int LPMC_OUTEN_BIT     = 4;
	localparam int LPMC_WARMUP_LSB    = 2;
	localparam int LPMC_DV1_BIT       = 1;
	localparam int LPMC_OSC_EN_BIT    = 7;
	localparam int LPMC_CLK_SEL_BIT   = 5;
	localparam int LPMC_IDLE_BIT      = 4;
	localparam int LPMC_MASTER_EN_BIT = 7;
	localparam int LPMC_NUM_INT    = 5;
	localparam int LPMC_WAKE_INT   = 4;
	// ==========================================
	// reset values
	localparam logic [7:0] LPMC_RST_SYS_CTRL_1 = 8'h00;
	localparam logic [7:0] LPMC_RST_SYS_CTRL_2 = 8'h80;
	localparam logic [7:0] LPMC_RST_INT_CTRL   = 8'h00;
	// ==========================================
	// warm-up timing, rounded up to whole pclk cycles
	localparam int LPMC_CLK_PERIOD_NS = 40;
	localparam int LPMC_WARMUP_00_NS  = 9831000;
	localparam int LPMC_WARMUP_01_NS  = 3277000;
	localparam int LPMC_WARMUP_10_NS  = 819000;
	localparam int LPMC_WARMUP_00_CYC = (LPMC_WARMUP_00_NS + LPMC_CLK_PERIOD_NS - 1) / LPMC_CLK_PERIOD_NS;
	localparam int LPMC_WARMUP_01_CYC = (LPMC_WARMUP_01_NS + LPMC_CLK_PERIOD_NS - 1) / LPMC_CLK_PERIOD_NS;
	localparam int LPMC_WARMUP_10_CYC = (LPMC_WARMUP_10_NS + LPMC_CLK_PERIOD_NS - 1) / LPMC_CLK_PERIOD_NS;
	localparam int LPMC_CNT_W         = 20;

	typedef enum logic [1:0] {LPMC_NORMAL, LPMC_STOP, LPMC_WARMUP, LPMC_IDLE} lpmc_mode_t;
endpackage

// file: verilog/lpmc_sync.sv
// two-flop synchroniser for a bus of asynchronous pins
// assumes the pins are quasi-static relative to pclk
module lpmc_sync
	import lpmc_pkg::*;
#(
	parameter int W = 1
)(
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] stage1;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			stage1   <= '0;
			sync_out <= '0;
		end
		else
		begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end
endmodule

// file: verilog/lpmc_warmup_timer.sv
// down-counter that times the oscillator warm-up interval
// assumes start is a one-cycle pulse and load is nonzero
module lpmc_warmup_timer
	import lpmc_pkg::*;
(
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  start,
	input  wire logic [LPMC_CNT_W-1:0] load,
	output logic                       busy,
	output logic                       done
);
	logic [LPMC_CNT_W-1:0] count;
	wire                   last = busy && (count == LPMC_CNT_W'(1));

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			count <= '0;
			busy  <= 1'b0;
			done  <= 1'b0;
		end
		else
		begin
			done <= last;
			if (start)
			begin
				count <= load;
				busy  <= 1'b1;
			end
			else if (busy)
			begin
				count <= count - LPMC_CNT_W'(1);
				busy  <= !last;
			end
		end
	end
endmodule

// file: verilog/lpmc_ctrl.sv
// low-power mode controller: STOP and IDLE sequencing with APB registers
// assumes APB master on pclk, async wake and interrupt pins, presetn from the reset pin
//
// How it works
// RULE1: stop bit write enters STOP
// RULE2: oscillator halted while stopped
// RULE3: core state frozen across STOP
// RULE4: timing generator cleared on STOP entry
// RULE5: level mode wakes on high pin
// RULE6: level mode, pin high: skip to warm-up
// RULE7: software checks pin low before STOP
// RULE8: warm-up always completes, never re-stops
// RULE9: mode switched while stopped needs edge
// RULE10: edge mode stops anyway, wakes on rise
// RULE11: warm-up runs oscillator, core stays idle
// RULE12: warm-up length by select, doubled option
// RULE13: resume after warm-up, generator from zero
// RULE14: reset pin aborts STOP or IDLE
// RULE15: pin change during STOP sets latch
// RULE16: software masks interrupts around STOP
// RULE17: idle bit write halts CPU, watchdog
// RULE18: core state frozen across IDLE
// RULE19: master off: enabled interrupt resumes inline
// RULE20: software clears latch after inline wake
// RULE21: master on: enabled interrupt vectors
// RULE22: pending watchdog interrupt blocks IDLE
// RULE23: STOP release clears the stop bit
// RULE24: exit mode zero restores normal clocks
//
// The implementer's own choices: the register addresses and the APB slave port.
module lpmc_ctrl
	import lpmc_pkg::*;
#(
	parameter int unsigned WARMUP_CYC_00 = LPMC_WARMUP_00_CYC,
	parameter int unsigned WARMUP_CYC_01 = LPMC_WARMUP_01_CYC,
	parameter int unsigned WARMUP_CYC_10 = LPMC_WARMUP_10_CYC
)(
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [7:0]              paddr,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	input  wire logic                    port2_bit0,
	input  wire logic [LPMC_NUM_INT-2:0] ext_int_pins,
	input  wire logic                    wdt_int_pending,
	output logic                         hf_osc_run,
	output logic                         sysclk_sel,
	output logic                         core_hold,
	output logic                         cpu_halt,
	output logic                         wdt_halt,
	output logic                         periph_halt,
	output logic                         tg_clear,
	output logic                         cpu_resume,
	output logic                         int_vector_req,
	output logic                         wdt_service
);
	// ==========================================
	// state and registers
	lpmc_mode_t              mode;
	lpmc_mode_t              next_mode;
	logic [7:0]              sys_ctrl_1;
	logic [7:0]              sys_ctrl_2;
	logic [7:0]              int_ctrl;
	logic [LPMC_NUM_INT-1:0] int_latch;
	logic [LPMC_NUM_INT-1:0] pins_sync;
	logic [LPMC_NUM_INT-1:0] pins_prev;
	logic                    need_edge;
	logic                    timer_busy;
	logic                    timer_done;
	logic [LPMC_CNT_W-1:0]   warmup_load;

	// ==========================================
	// pin synchronisers
	lpmc_sync #(.W(LPMC_NUM_INT)) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in ({port2_bit0, ext_int_pins}),
		.sync_out (pins_sync)
	);

	wire wake_hi   = pins_sync[LPMC_WAKE_INT];
	wire wake_rise = wake_hi && !pins_prev[LPMC_WAKE_INT];

	// ==========================================
	// APB decode
	wire wr_en     = psel && penable && pwrite;
	wire rd_setup  = psel && !penable && !pwrite;
	wire hit_c1    = paddr == LPMC_ADDR_SYS_CTRL_1;
	wire hit_c2    = paddr == LPMC_ADDR_SYS_CTRL_2;
	wire hit_ic    = paddr == LPMC_ADDR_INT_CTRL;
	wire hit_lat   = paddr == LPMC_ADDR_INT_LATCH;
	wire hit_st    = paddr == LPMC_ADDR_STATUS;
	wire mapped    = hit_c1 || hit_c2 || hit_ic || hit_lat || hit_st;
	wire wr_c1     = wr_en && hit_c1;
	wire wr_c2     = wr_en && hit_c2;
	wire wr_ic     = wr_en && hit_ic;
	wire wr_lat    = wr_en && hit_lat;

	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// ==========================================
	// mode requests
	wire release_mode_sel = sys_ctrl_1[LPMC_REL_MODE_BIT];
	wire stop_exit_mode   = sys_ctrl_1[LPMC_EXIT_MODE_BIT];
	wire stop_req         = wr_c1 && pwdata[LPMC_STOP_BIT] && mode == LPMC_NORMAL;
	wire stop_skip        = stop_req && pwdata[LPMC_REL_MODE_BIT] && wake_hi;
	wire idle_req         = wr_c2 && pwdata[LPMC_IDLE_BIT] && mode == LPMC_NORMAL;
	wire idle_block       = idle_req && wdt_int_pending;
	wire int_master_en    = int_ctrl[LPMC_MASTER_EN_BIT];
	wire int_wake         = |(int_latch & int_ctrl[LPMC_NUM_INT-1:0]);
	wire stop_wake        = wake_rise || (release_mode_sel && !need_edge && wake_hi);
	wire in_stop    = mode == LPMC_STOP || mode == LPMC_WARMUP;
	wire warm_start = (mode == LPMC_STOP && stop_wake) || stop_skip;
	wire warm_end   = mode == LPMC_WARMUP && timer_done;

	// ==========================================
	// warm-up length select
	wire [1:0] warmup_sel = sys_ctrl_1[LPMC_WARMUP_LSB +: 2];
	wire [LPMC_CNT_W-1:0] base_cyc =
		(warmup_sel == 2'h0) ? LPMC_CNT_W'(WARMUP_CYC_00) :
		(warmup_sel == 2'h1) ? LPMC_CNT_W'(WARMUP_CYC_01) :
		LPMC_CNT_W'(WARMUP_CYC_10); // reserved code 11 falls back to the shortest [RULE12]
	assign warmup_load = sys_ctrl_1[LPMC_DV1_BIT] ? (base_cyc << 1) : base_cyc; // [RULE12]

	lpmc_warmup_timer u_timer (
		.pclk    (pclk),
		.presetn (presetn),
		.start   (warm_start),
		.load    (warmup_load),
		.busy    (timer_busy),
		.done    (timer_done)
	);

	// ==========================================
	// mode sequencer
	always_comb
	begin
		next_mode = mode;
		unique case (mode)
			LPMC_NORMAL:
				if (stop_skip)
					next_mode = LPMC_WARMUP; // [RULE6]
				else if (stop_req)
					next_mode = LPMC_STOP; // [RULE1] [RULE10]
				else if (idle_req && !idle_block)
					next_mode = LPMC_IDLE; // [RULE17] [RULE22]
			LPMC_STOP:
				if (stop_wake)
					next_mode = LPMC_WARMUP; // [RULE5] [RULE9] [RULE10]
			LPMC_WARMUP:
				if (timer_done)
					next_mode = LPMC_NORMAL; // [RULE8] [RULE13]
			LPMC_IDLE:
				if (int_wake)
					next_mode = LPMC_NORMAL; // [RULE19] [RULE21]
		endcase
	end

	// reset pin drives presetn, so either low-power mode falls straight back to normal
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mode <= LPMC_NORMAL; // [RULE14]
		else
			mode <= next_mode;
	end

	// edge memory: set on edge-mode entry, a rise clears it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			need_edge <= 1'b0;
		else if (stop_req)
			need_edge <= !pwdata[LPMC_REL_MODE_BIT]; // [RULE9]
		else if (wake_rise)
			need_edge <= 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pins_prev <= '0;
		else
			pins_prev <= pins_sync;
	end

	// ==========================================
	// control registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sys_ctrl_1 <= LPMC_RST_SYS_CTRL_1;
		else if (wr_c1 && mode == LPMC_NORMAL)
			sys_ctrl_1 <= stop_skip ? (pwdata[7:0] & ~8'h80) : pwdata[7:0];
		else if (warm_end)
			sys_ctrl_1[LPMC_STOP_BIT] <= 1'b0; // [RULE23]
		else if (mode == LPMC_STOP && wr_c1)
			sys_ctrl_1[LPMC_REL_MODE_BIT] <= pwdata[LPMC_REL_MODE_BIT];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sys_ctrl_2 <= LPMC_RST_SYS_CTRL_2;
		else if (warm_end && !stop_exit_mode)
		begin
			sys_ctrl_2[LPMC_OSC_EN_BIT]  <= 1'b1; // [RULE24]
			sys_ctrl_2[LPMC_CLK_SEL_BIT] <= 1'b0; // [RULE24]
		end
		else if (mode == LPMC_IDLE && int_wake)
			sys_ctrl_2[LPMC_IDLE_BIT] <= 1'b0;
		else if (wr_c2 && mode == LPMC_NORMAL)
			sys_ctrl_2 <= {pwdata[7], 1'b0, pwdata[5], pwdata[4] && !idle_block, 4'h0};
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			int_ctrl <= LPMC_RST_INT_CTRL;
		else if (wr_ic)
			int_ctrl <= pwdata[7:0] & 8'h9F;
	end

	// ==========================================
	// interrupt latches: pin edges set, a loaded zero clears, set wins
	genvar gi;
	generate
		for (gi = 0; gi < LPMC_NUM_INT; gi++)
		begin : g_latch
			wire changed = pins_sync[gi] != pins_prev[gi];
			// any change counts in STOP or warm-up; a falling edge otherwise
			wire set_ev  = in_stop ? changed : (changed && !pins_sync[gi]); // [RULE15]
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					int_latch[gi] <= 1'b0;
				else if (set_ev)
					int_latch[gi] <= 1'b1;
				else if (wr_lat)
					int_latch[gi] <= pwdata[gi];
			end
		end
	endgenerate

	// ==========================================
	// read data, captured in the setup phase
	wire [31:0] rd_mux =
		hit_c1 ? {24'h0, sys_ctrl_1} :
		hit_c2 ? {24'h0, sys_ctrl_2} :
		hit_ic ? {24'h0, int_ctrl} :
		hit_lat ? {27'h0, int_latch} :
		hit_st ? {26'h0, timer_busy, need_edge, wake_hi, 1'b0, mode} : 32'h0;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0;
		else if (rd_setup)
			prdata <= rd_mux;
	end

	// ==========================================
	// outputs to the clock and core
	// pclk is the always-on domain; hf_osc_run gates the oscillator for the rest
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			hf_osc_run     <= 1'b1;
			sysclk_sel     <= 1'b0;
			core_hold      <= 1'b0;
			cpu_halt       <= 1'b0;
			wdt_halt       <= 1'b0;
			periph_halt    <= 1'b0;
			tg_clear       <= 1'b0;
			cpu_resume     <= 1'b0;
			int_vector_req <= 1'b0;
			wdt_service    <= 1'b0;
		end
		else
		begin
			hf_osc_run     <= next_mode != LPMC_STOP; // [RULE2] [RULE11]
			sysclk_sel     <= sys_ctrl_2[LPMC_CLK_SEL_BIT];
			core_hold      <= next_mode != LPMC_NORMAL; // [RULE3] [RULE18]
			cpu_halt       <= next_mode != LPMC_NORMAL; // [RULE17]
			wdt_halt       <= next_mode != LPMC_NORMAL;
			periph_halt    <= next_mode == LPMC_STOP || next_mode == LPMC_WARMUP; // [RULE11]
			tg_clear       <= next_mode == LPMC_STOP || next_mode == LPMC_WARMUP; // [RULE4]
			cpu_resume     <= warm_end || (mode == LPMC_IDLE && int_wake); // [RULE13]
			int_vector_req <= mode == LPMC_IDLE && int_wake && int_master_en; // [RULE21]
			wdt_service    <= idle_block; // [RULE22]
		end
	end

	// ==========================================
	// assertions
	a_stop_enter: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
		stop_req && !stop_skip |=> mode == LPMC_STOP && !hf_osc_run)
		else $error("stop request did not enter STOP");

	a_osc_halt: assert property (@(posedge pclk) disable iff (!presetn) // [RULE2]
		mode == LPMC_STOP && $past(mode) == LPMC_STOP |-> !hf_osc_run && core_hold)
		else $error("oscillator running in STOP");

	a_tg_clear: assert property (@(posedge pclk) disable iff (!presetn) // [RULE4]
		in_stop |-> tg_clear)
		else $error("timing generator not cleared in STOP");

	a_level_skip: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
		stop_skip |=> mode == LPMC_WARMUP && !sys_ctrl_1[LPMC_STOP_BIT])
		else $error("level-mode stop with pin high not skipped");

	a_warmup_commit: assert property (@(posedge pclk) disable iff (!presetn) // [RULE8]
		mode == LPMC_WARMUP |=> mode == LPMC_WARMUP || mode == LPMC_NORMAL)
		else $error("warm-up left for a mode other than normal");

	a_edge_exit: assert property (@(posedge pclk) disable iff (!presetn) // [RULE10]
		mode == LPMC_STOP && wake_rise |=> mode == LPMC_WARMUP ##0 timer_busy)
		else $error("rising wake edge did not start warm-up");

	a_stop_clear: assert property (@(posedge pclk) disable iff (!presetn) // [RULE23]
		warm_end |=> !sys_ctrl_1[LPMC_STOP_BIT] && mode == LPMC_NORMAL && cpu_resume)
		else $error("stop bit not cleared on release");

	a_exit_clocks: assert property (@(posedge pclk) disable iff (!presetn) // [RULE24]
		warm_end && !stop_exit_mode |=>
		sys_ctrl_2[LPMC_OSC_EN_BIT] && !sys_ctrl_2[LPMC_CLK_SEL_BIT])
		else $error("normal clocks not restored on exit");

	a_idle_vector: assert property (@(posedge pclk) disable iff (!presetn) // [RULE21]
		mode == LPMC_IDLE && int_wake |=> cpu_resume && (int_vector_req == $past(int_master_en)))
		else $error("idle release vector mismatch");

	a_idle_wdt: assert property (@(posedge pclk) disable iff (!presetn) // [RULE22]
		idle_block |=> mode == LPMC_NORMAL && wdt_service)
		else $error("idle entered with watchdog pending");

	a_latch_set: assert property (@(posedge pclk) disable iff (!presetn) // [RULE15]
		in_stop && pins_sync[0] != pins_prev[0] |=> int_latch[0])
		else $error("pin change in STOP did not set latch");

	c_edge_cycle: cover property (@(posedge pclk) disable iff (!presetn)
		mode == LPMC_STOP ##1 mode == LPMC_WARMUP);
	c_idle_vec: cover property (@(posedge pclk) disable iff (!presetn) int_vector_req);
	c_level_skip: cover property (@(posedge pclk) disable iff (!presetn) stop_skip);
endmodule

// file: bench/lpmc_wake_src.sv
// wake pin and external interrupt pins, as the far side drives them
// assumes the bench calls set from the pclk domain
module lpmc_wake_src
	import lpmc_pkg::*;
(
	input  wire logic                    pclk,
	output logic                         wake,
	output logic [LPMC_NUM_INT-2:0]      pins
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		wake = 1'b0;
		pins = '0;
	end
	// levels are held between calls, long enough for the two-flop syncs
	task automatic set(input logic w, input logic [LPMC_NUM_INT-2:0] p);
		@(posedge pclk);
		wake <= w;
		pins <= p;
	endtask
endmodule

// file: bench/low_power_mode_ctrl_test.sv
// self-checking bench for the low-power mode controller
// assumes lpmc_pkg, the design files and the wake source model compile first
module low_power_mode_ctrl_test
	import lpmc_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================
	// signals
	localparam int W00 = 40;
	localparam int W01 = 20;
	localparam int W10 = 10;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        wake, wdt_pend, err;
	logic [3:0]  pins;
	logic        hf_osc_run, sysclk_sel, core_hold, cpu_halt, wdt_halt, periph_halt;
	logic        tg_clear, cpu_resume, int_vector_req, wdt_service;
	int          miscompares, checked, svc, stop_cyc;
	lpmc_ctrl #(.WARMUP_CYC_00(W00), .WARMUP_CYC_01(W01), .WARMUP_CYC_10(W10)) dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.port2_bit0(wake), .ext_int_pins(pins), .wdt_int_pending(wdt_pend),
		.hf_osc_run(hf_osc_run), .sysclk_sel(sysclk_sel), .core_hold(core_hold),
		.cpu_halt(cpu_halt), .wdt_halt(wdt_halt), .periph_halt(periph_halt),
		.tg_clear(tg_clear), .cpu_resume(cpu_resume), .int_vector_req(int_vector_req),
		.wdt_service(wdt_service));
	lpmc_wake_src src (.pclk(pclk), .wake(wake), .pins(pins));
	always #20 pclk = ~pclk;
	always @(negedge pclk)
	begin
		if (wdt_service === 1'b1)
			svc++;
		if (hf_osc_run === 1'b0)
			stop_cyc++;
	end
	// ==========================================
	// helpers
	function automatic int warm_len(logic [1:0] s, logic d);
		int n;
		n = (s == 2'h0) ? W00 : (s == 2'h1) ? W01 : W10;
		return d ? 2 * n : n;
	endfunction
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1);
		rd      = prdata;
		err     = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		chk("wait states", 32'h1, 32'(n));
	endtask
	task automatic rdm(input string nm, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rd & m);
	endtask
	// counts warm-up cycles (oscillator on, peripherals held) until resume
	task automatic wait_resume(output int warm, output logic vec);
		int i;
		warm = 0;
		vec  = 1'b0;
		for (i = 0; i < 2000; i++)
		begin
			@(negedge pclk);
			if (periph_halt === 1'b1 && hf_osc_run === 1'b1)
				warm++;
			if (int_vector_req === 1'b1)
				vec = 1'b1;
			if (cpu_resume === 1'b1)
				break;
		end
		if (i == 2000)
			chk("resume", 32'h1, 32'h0);
	endtask
	task automatic wrap_up();
		$display("miscompares=%0d checked=%0d", miscompares, checked);
		if (miscompares == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge pclk);
		miscompares++;
		wrap_up();
	end
	// ==========================================
	// scenarios
	initial
	begin
		logic [1:0] sel;
		logic       dv, vec;
		logic [3:0] pv;
		int         n, w, k, idx, s0;
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		wdt_pend = 1'b0;
		pv = 4'h0;
		miscompares = 0;
		checked = 0;
		svc = 0;
		stop_cyc = 0;
		void'($urandom(32'hD8FE2E22));
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rdm("ctrl1 reset", LPMC_ADDR_SYS_CTRL_1, 32'hFC, 32'h0);
		rdm("ctrl2 reset", LPMC_ADDR_SYS_CTRL_2, 32'hF0, 32'h80);
		apb(1'b0, 8'h14, 32'h0);
		chk("unmapped err", 32'h1, err);
		chk("unmapped data", 32'h0, rd);
		// edge mode, every warm-up code, pin high at entry on odd passes
		for (k = 0; k < 4; k++)
		begin
			sel = k[1:0];
			dv  = 1'($urandom % 2);
			n   = warm_len(sel, dv);
			apb(1'b1, LPMC_ADDR_INT_CTRL, 32'h0);
			src.set(k[0], pv);
			repeat (3) @(posedge pclk);
			apb(1'b1, LPMC_ADDR_INT_LATCH, 32'h0);
			apb(1'b1, LPMC_ADDR_SYS_CTRL_1, {24'h0, 4'h9, sel, dv, 1'b0});
			repeat (3) @(negedge pclk);
			chk("oscillator", 32'h0, hf_osc_run);
			chk("tg clear", 32'h1, tg_clear);
			chk("core hold", 32'h1, core_hold);
			rdm("mode stop", LPMC_ADDR_STATUS, 32'h3, 32'h1);
			pv = ~pv;
			src.set(1'b0, pv);
			repeat (3) @(posedge pclk);
			fork
				wait_resume(w, vec);
				begin
					src.set(1'b1, pv);
					repeat (6) @(posedge pclk);
					src.set(1'b0, pv);
				end
			join
			chk("warm-up span", 32'h1, 32'(w >= n && w <= n + 3));
			rdm("stop bit", LPMC_ADDR_SYS_CTRL_1, 32'h80, 32'h0);
			rdm("clock sel", LPMC_ADDR_SYS_CTRL_2, 32'hA0, 32'h80);
			chk("sysclk pin", 32'h0, sysclk_sel);
			rdm("latch set", LPMC_ADDR_INT_LATCH, 32'h1, 32'h1);
			chk("tg released", 32'h0, tg_clear);
		end
		// level mode with the pin already high skips STOP
		src.set(1'b1, pv);
		repeat (3) @(posedge pclk);
		s0 = stop_cyc;
		fork
			wait_resume(w, vec);
			apb(1'b1, LPMC_ADDR_SYS_CTRL_1, 32'hD8);
		join
		chk("no stop", s0, stop_cyc);
		chk("direct warm-up", 32'h1, 32'(w >= W10 && w <= W10 + 3));
		// level mode, pin low first, wakes on high level
		src.set(1'b0, pv);
		repeat (3) @(posedge pclk);
		rdm("pin low", LPMC_ADDR_STATUS, 32'h8, 32'h0);
		apb(1'b1, LPMC_ADDR_SYS_CTRL_1, 32'hD8);
		repeat (3) @(negedge pclk);
		chk("level stop", 32'h0, hf_osc_run);
		fork
			wait_resume(w, vec);
			src.set(1'b1, pv);
		join
		chk("level wake", 32'h1, 32'(w >= W10 && w <= W10 + 3));
		// edge entry with pin high, then level mode chosen while stopped
		apb(1'b1, LPMC_ADDR_SYS_CTRL_1, 32'h98);
		apb(1'b1, LPMC_ADDR_SYS_CTRL_1, 32'hD8);
		repeat (6) @(negedge pclk);
		chk("edge needed", 32'h0, hf_osc_run);
		src.set(1'b0, pv);
		repeat (3) @(posedge pclk);
		fork
			wait_resume(w, vec);
			src.set(1'b1, pv);
		join
		chk("edge wake", 32'h1, 32'(w >= W10 && w <= W10 + 3));
		// IDLE, inline then vectored release
		for (k = 0; k < 2; k++)
		begin
			idx = $urandom % 4;
			src.set(1'b0, 4'hF);
			repeat (3) @(posedge pclk);
			apb(1'b1, LPMC_ADDR_INT_LATCH, 32'h0);
			apb(1'b1, LPMC_ADDR_INT_CTRL, {24'h0, k[0], 2'h0, 5'(1 << idx)});
			apb(1'b1, LPMC_ADDR_SYS_CTRL_2, 32'h90);
			repeat (3) @(negedge pclk);
			chk("cpu halt", 32'h1, cpu_halt);
			chk("wdt halt", 32'h1, wdt_halt);
			chk("periph run", 32'h0, periph_halt);
			chk("state hold", 32'h1, core_hold);
			fork
				wait_resume(w, vec);
				src.set(1'b0, ~(4'h1 << idx));
			join
			chk("vectoring", 32'(k), vec);
			rdm("latch kept", LPMC_ADDR_INT_LATCH, 32'h1F, 32'(1 << idx));
			apb(1'b1, LPMC_ADDR_INT_LATCH, 32'h0);
			rdm("latch clear", LPMC_ADDR_INT_LATCH, 32'h1F, 32'h0);
		end
		// pending watchdog interrupt refuses IDLE
		@(posedge pclk);
		wdt_pend <= 1'b1;
		n = svc;
		apb(1'b1, LPMC_ADDR_SYS_CTRL_2, 32'h90);
		wdt_pend <= 1'b0;
		repeat (2) @(negedge pclk);
		chk("wdt service", n + 1, svc);
		chk("no idle", 32'h0, cpu_halt);
		rdm("idle bit", LPMC_ADDR_SYS_CTRL_2, 32'h10, 32'h0);
		// reset pin aborts STOP
		apb(1'b1, LPMC_ADDR_SYS_CTRL_1, 32'h98);
		repeat (3) @(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(negedge pclk);
		chk("reset osc", 32'h1, hf_osc_run);
		chk("reset hold", 32'h0, core_hold);
		@(posedge pclk);
		presetn <= 1'b1;
		rdm("reset ctrl1", LPMC_ADDR_SYS_CTRL_1, 32'hFC, 32'h0);
		rdm("reset mode", LPMC_ADDR_STATUS, 32'h3, 32'h0);
		wrap_up();
	end
endmodule
